// [eeprom_host_defines.vh]
// Purpose: constants for the byte-wide eeprom host controller
// Assumes: mclk at 10 MHz (100 ns period)
// Notes: times in ns/us/ms, cycle counts derived from them
`ifndef EEPROM_HOST_DEFINES_VH
`define EEPROM_HOST_DEFINES_VH

// -----------------------------------------------------------------
// array geometry
// -----------------------------------------------------------------
`define ADDR_WIDTH 11
`define DATA_WIDTH 8
`define ARRAY_BYTES 2048
`define ID_SPACE_BASE 11'h07E0
`define ID_SPACE_LAST 11'h07FF
`define POLL_BIT_POS 7

// -----------------------------------------------------------------
// timing
// -----------------------------------------------------------------
`define CLK_PERIOD_NS 100
`define READ_ACCESS_NS 250
`define WRITE_PULSE_NS 100
`define WRITE_PULSE_MAX_NS 1000
`define SETUP_HOLD_NS 10
`define WRITE_CYCLE_MAX_US 1000
`define FAST_WRITE_CYCLE_MAX_US 200
`define CLEAR_PULSE_MS 10
`define CLEAR_SETUP_US 1
`define POWER_ON_DELAY_MS 5
`define READ_CYCLES ((`READ_ACCESS_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS + 1)
`define WRITE_PULSE_CYCLES ((`WRITE_PULSE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS + 1)
`define SETUP_CYCLES ((`SETUP_HOLD_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define WRITE_TIMEOUT_CYCLES (`WRITE_CYCLE_MAX_US * 1000 / `CLK_PERIOD_NS)
`define CLEAR_PULSE_CYCLES (`CLEAR_PULSE_MS * 1000000 / `CLK_PERIOD_NS)
`define CLEAR_SETUP_CYCLES (`CLEAR_SETUP_US * 1000 / `CLK_PERIOD_NS)
`define POWER_ON_CYCLES (`POWER_ON_DELAY_MS * 1000000 / `CLK_PERIOD_NS)

// -----------------------------------------------------------------
// command codes on the user port
// -----------------------------------------------------------------
`define CMD_READ 2'h0
`define CMD_WRITE 2'h1
`define CMD_CLEAR 2'h2

`endif

// [eeprom_host_timer.v]
// Purpose: down-counter used for pulse widths and timeouts
// Assumes: load may arrive while the count is still running, as on a watchdog reload
// Notes: load wins over count; done is registered
`timescale 1ns/100ps
`default_nettype none

module eeprom_host_timer #(
	parameter WIDTH = 24
) (
	// clock and reset
	input wire mclk,
	input wire reset,
	// control
	input wire load,
	input wire [WIDTH-1:0] load_value,
	// status
	output reg done
);

reg [WIDTH-1:0] count;

// -----------------------------------------------------------------
// countdown
// -----------------------------------------------------------------
// done is high exactly while the count sits at zero; a pending load clears it only at the next edge
always @(posedge mclk or posedge reset) begin
	if (reset) begin
		count <= {WIDTH{1'b0}};
		done <= 1'b1;
	end else if (load) begin
		count <= load_value;
		done <= (load_value == {WIDTH{1'b0}});
	end else if (count != {WIDTH{1'b0}}) begin
		count <= count - {{(WIDTH-1){1'b0}}, 1'b1};
		done <= (count == {{(WIDTH-1){1'b0}}, 1'b1});
	end
end

endmodule // eeprom_host_timer

`default_nettype wire

// [eeprom_host.v]
// Purpose: host controller driving a 2K x 8 byte-wide eeprom by its pins
// Assumes: pin inputs synchronous to mclk; high-voltage levels driven by
//   board switches controlled through the *_hv outputs
// Notes: one request at a time; completion waits on busy release and bit-7 polling both
`timescale 1ns/100ps
`default_nettype none
`include "eeprom_host_defines.vh"

// Functional notes
// [RULE_01] 2048 bytes, 11-bit address
// [RULE_02] read with select, drive low
// [RULE_03] device floats bus when deselected
// [RULE_04] write pulses strobe, output drive high
// [RULE_05] address latched on later falling edge
// [RULE_06] data latched on first rising edge
// [RULE_07] device erases byte before programming
// [RULE_08] write self-timed, bus freed
// [RULE_09] write time at most 1 ms
// [RULE_10] open-drain busy low during write
// [RULE_11] in-write read returns inverted bit 7
// [RULE_12] finished write returns true data
// [RULE_13] wait for completion before next access
// [RULE_14] no write with drive low
// [RULE_15] writes blocked under supply threshold
// [RULE_16] 5 ms power-on write block
// [RULE_17] clear: drive high-voltage, 10 ms strobe
// [RULE_18] id space via high-voltage address line
// [RULE_19] device may ignore writes while busy
module eeprom_host #(
	parameter POWER_ON_CYCLES = `POWER_ON_CYCLES,
	parameter WRITE_TIMEOUT_CYCLES = `WRITE_TIMEOUT_CYCLES,
	parameter CLEAR_PULSE_CYCLES = `CLEAR_PULSE_CYCLES
) (
	// clock and reset
	input wire mclk,
	input wire reset,
	// user request
	input wire req_valid,
	input wire [1:0] req_cmd,
	input wire req_id_space,
	input wire [`ADDR_WIDTH-1:0] req_addr,
	input wire [`DATA_WIDTH-1:0] req_wdata,
	output reg req_ready,
	// user answer
	output reg resp_valid,
	output reg [`DATA_WIDTH-1:0] resp_rdata,
	output reg resp_timeout,
	// device pins
	output reg [`ADDR_WIDTH-1:0] byte_address,
	output reg id_space_select_line_hv,
	output reg chip_select_n,
	output reg output_drive_n,
	output reg output_drive_hv,
	output reg write_strobe_n,
	input wire [`DATA_WIDTH-1:0] data_bus_in,
	output reg [`DATA_WIDTH-1:0] data_bus_out,
	output reg data_bus_oe,
	input wire busy_n
);

// -----------------------------------------------------------------
// states and locals
// -----------------------------------------------------------------
localparam S_POWERUP = 4'd0;
localparam S_IDLE = 4'd1;
localparam S_RD_WAIT = 4'd2;
localparam S_WR_SETUP = 4'd3;
localparam S_WR_PULSE = 4'd4;
localparam S_WR_HOLD = 4'd5;
localparam S_POLL = 4'd6;
localparam S_POLL_GAP = 4'd7;
localparam S_CL_SETUP = 4'd8;
localparam S_CL_PULSE = 4'd9;
localparam S_CL_HOLD = 4'd10;
localparam S_DONE = 4'd11;
localparam TW = 28;
localparam [TW-1:0] RD_LOAD = `READ_CYCLES;
localparam [TW-1:0] WP_LOAD = `WRITE_PULSE_CYCLES;
localparam [TW-1:0] SU_LOAD = `SETUP_CYCLES + 1;
localparam [TW-1:0] CS_LOAD = `CLEAR_SETUP_CYCLES;

reg [3:0] state;
reg [3:0] next_state;
reg [`DATA_WIDTH-1:0] wr_byte;
reg timer_load;
reg [TW-1:0] timer_value;
wire timer_done;
reg wd_load;
wire wd_done;
reg [TW-1:0] poll_gap_cnt;

// shared pulse/access timer
eeprom_host_timer #(.WIDTH(TW)) u_timer (
	.mclk(mclk),
	.reset(reset),
	.load(timer_load),
	.load_value(timer_value),
	.done(timer_done)
);

// watchdog on the self-timed write, bounded by the longest write time
eeprom_host_timer #(.WIDTH(TW)) u_watchdog (
	.mclk(mclk),
	.reset(reset),
	.load(wd_load),
	.load_value(WRITE_TIMEOUT_CYCLES[TW-1:0]),
	.done(wd_done)
);

// -----------------------------------------------------------------
// next-state logic
// -----------------------------------------------------------------
// polling ends on busy released and true bit 7 both, so a board
// without the busy pull-up completes only through the watchdog timeout
always @* begin
	next_state = state;
	timer_load = 1'b0;
	timer_value = {TW{1'b0}};
	wd_load = 1'b0;
	case (state)
	S_POWERUP: begin
		if (poll_gap_cnt == POWER_ON_CYCLES[TW-1:0]) // RULE_16
			next_state = S_IDLE;
	end
	S_IDLE: begin
		if (req_valid) begin
			timer_load = 1'b1;
			if (req_cmd == `CMD_READ) begin
				next_state = S_RD_WAIT; // RULE_02
				timer_value = RD_LOAD;
			end else if (req_cmd == `CMD_CLEAR) begin
				next_state = S_CL_SETUP; // RULE_17
				timer_value = CS_LOAD;
			end else begin
				next_state = S_WR_SETUP; // RULE_04
				timer_value = SU_LOAD;
			end
		end
	end
	S_RD_WAIT: begin
		if (timer_done)
			next_state = S_DONE;
	end
	S_WR_SETUP: begin
		if (timer_done) begin
			next_state = S_WR_PULSE; // RULE_05
			timer_load = 1'b1;
			timer_value = WP_LOAD;
		end
	end
	S_WR_PULSE: begin
		if (timer_done) begin
			next_state = S_WR_HOLD; // RULE_06
			timer_load = 1'b1;
			timer_value = SU_LOAD;
		end
	end
	S_WR_HOLD: begin
		if (timer_done) begin
			next_state = S_POLL_GAP; // RULE_08
			wd_load = 1'b1;
			timer_load = 1'b1;
			timer_value = RD_LOAD;
		end
	end
	S_POLL_GAP: begin
		if (timer_done)
			next_state = S_POLL;
	end
	S_POLL: begin // RULE_13
		if (busy_n && (data_bus_in[`POLL_BIT_POS] ==
				wr_byte[`POLL_BIT_POS])) // RULE_12
			next_state = S_DONE;
		else if (wd_done)
			next_state = S_DONE; // RULE_09
	end
	S_CL_SETUP: begin
		if (timer_done) begin
			next_state = S_CL_PULSE;
			timer_load = 1'b1;
			timer_value = CLEAR_PULSE_CYCLES[TW-1:0]; // RULE_17
		end
	end
	S_CL_PULSE: begin
		if (timer_done) begin
			next_state = S_CL_HOLD;
			timer_load = 1'b1;
			timer_value = CS_LOAD;
		end
	end
	S_CL_HOLD: begin
		if (timer_done)
			next_state = S_DONE;
	end
	S_DONE: begin
		next_state = S_IDLE;
	end
	default: begin
		next_state = S_IDLE;
	end
	endcase
end

// -----------------------------------------------------------------
// state register and power-on hold-off
// -----------------------------------------------------------------
// power-on hold-off has its own counter so the shared timer stays free
always @(posedge mclk or posedge reset) begin
	if (reset)
		state <= S_POWERUP;
	else
		state <= next_state;
end

// power-on count; ready stays low so no early write is lost silently
always @(posedge mclk or posedge reset) begin
	if (reset)
		poll_gap_cnt <= {TW{1'b0}};
	else if (state == S_POWERUP && poll_gap_cnt != POWER_ON_CYCLES[TW-1:0])
		poll_gap_cnt <= poll_gap_cnt + {{(TW-1){1'b0}}, 1'b1}; // RULE_16
end

// -----------------------------------------------------------------
// pin and answer registers
// -----------------------------------------------------------------
always @(posedge mclk or posedge reset) begin
	if (reset) begin
		req_ready <= 1'b0;
		resp_valid <= 1'b0;
		resp_rdata <= 8'h00;
		resp_timeout <= 1'b0;
		byte_address <= 11'h000;
		id_space_select_line_hv <= 1'b0;
		chip_select_n <= 1'b1;
		output_drive_n <= 1'b1;
		output_drive_hv <= 1'b0;
		write_strobe_n <= 1'b1;
		data_bus_out <= 8'h00;
		data_bus_oe <= 1'b0;
		wr_byte <= 8'h00;
	end else begin
		resp_valid <= 1'b0;
		req_ready <= (next_state == S_IDLE);
		case (next_state)
		S_RD_WAIT, S_POLL_GAP, S_POLL: begin
			chip_select_n <= 1'b0;
			output_drive_n <= 1'b0; // RULE_02
			write_strobe_n <= 1'b1;
			data_bus_oe <= 1'b0; // RULE_03
		end
		S_WR_SETUP, S_WR_HOLD: begin
			chip_select_n <= 1'b0;
			output_drive_n <= 1'b1; // RULE_14
			write_strobe_n <= 1'b1;
			data_bus_oe <= 1'b1;
		end
		S_WR_PULSE, S_CL_PULSE: begin
			write_strobe_n <= 1'b0; // RULE_04
		end
		S_CL_SETUP, S_CL_HOLD: begin
			chip_select_n <= 1'b0;
			output_drive_n <= 1'b1;
			output_drive_hv <= 1'b1; // RULE_17
			write_strobe_n <= 1'b1;
			data_bus_oe <= 1'b0;
		end
		default: begin
			chip_select_n <= 1'b1;
			output_drive_n <= 1'b1;
			output_drive_hv <= 1'b0;
			write_strobe_n <= 1'b1;
			data_bus_oe <= 1'b0;
		end
		endcase
		// latch the request while idle; address held for the whole access
		if (state == S_IDLE && req_valid) begin
			byte_address <= req_addr; // RULE_01
			id_space_select_line_hv <= req_id_space; // RULE_18
			data_bus_out <= req_wdata;
			wr_byte <= req_wdata;
			resp_timeout <= 1'b0;
		end
		if (state == S_POLL && next_state == S_DONE)
			resp_timeout <= !(busy_n && (data_bus_in[`POLL_BIT_POS] ==
				wr_byte[`POLL_BIT_POS])); // RULE_10
		if ((state == S_RD_WAIT && timer_done) ||
				(state == S_POLL && next_state == S_DONE))
			resp_rdata <= data_bus_in;
		if (state == S_DONE) begin
			resp_valid <= 1'b1;
			id_space_select_line_hv <= 1'b0;
		end
	end
end

endmodule // eeprom_host

`default_nettype wire

// [eeprom_host_monitor.sv]
// Purpose: pin-level checks on the eeprom host controller
// Assumes: one clock domain, async active-high reset
// Notes: bound to every eeprom_host instance
`timescale 1ns/100ps
`default_nettype none
module eeprom_host_monitor #(
	parameter CLEAR_PULSE_CYCLES = 30
) (
	// clock and reset
	input wire logic mclk,
	input wire logic reset,
	// user side
	input wire logic req_valid,
	input wire logic req_ready,
	input wire logic resp_valid,
	// device pins
	input wire logic [10:0] byte_address,
	input wire logic id_space_select_line_hv,
	input wire logic chip_select_n,
	input wire logic output_drive_n,
	input wire logic output_drive_hv,
	input wire logic write_strobe_n,
	input wire logic [7:0] data_bus_out,
	input wire logic data_bus_oe,
	input wire logic busy_n
);
	// ---------------------------------------------
	// strobe-low length, for the clear pulse width
	// ---------------------------------------------
	// wide enough for the full-length clear pulse, not only short runs
	logic [31:0] low_cnt;
	always @(posedge mclk or posedge reset) begin
		if (reset)
			low_cnt <= 32'h0000_0000;
		else
			low_cnt <= write_strobe_n ? 32'h0000_0000 :
				low_cnt + 32'h0000_0001;
	end
	default clocking cb @(posedge mclk); endclocking
	default disable iff (reset);
	// ---------------------------------------------
	// assertions
	// ---------------------------------------------
	AST_READ_SAFE: assert property (!output_drive_n && !output_drive_hv
		|-> write_strobe_n && !data_bus_oe) else $error("bus clash in read");
	AST_WRITE_OE: assert property (!write_strobe_n && !output_drive_hv
		|-> output_drive_n && !chip_select_n) else $error("bad write pulse");
	AST_ADDR_STABLE: assert property (!chip_select_n && !$past(chip_select_n)
		|-> $stable(byte_address)) else $error("address moved in access");
	AST_DATA_HOLD: assert property ($rose(write_strobe_n) && !output_drive_hv
		|-> data_bus_oe && $stable(data_bus_out)) else $error("data not held");
	AST_BUSY_WAIT: assert property (!busy_n
		|-> write_strobe_n && !req_ready) else $error("access while busy");
	AST_POWER_ON: assert property ($fell(reset)
		|-> !req_ready [*8]) else $error("ready too early");
	AST_CLEAR_WIDTH: assert property ($rose(write_strobe_n) && output_drive_hv
		|-> low_cnt >= CLEAR_PULSE_CYCLES) else $error("clear pulse short");
	AST_ID_RANGE: assert property (id_space_select_line_hv
		|-> byte_address >= 11'h07e0) else $error("id address out of range");
	AST_DONE_BOUND: assert property (req_valid && req_ready
		|-> ##[1:300] resp_valid) else $error("request never answered");
endmodule // eeprom_host_monitor
bind eeprom_host eeprom_host_monitor #(.CLEAR_PULSE_CYCLES(CLEAR_PULSE_CYCLES)) mon (
	.mclk(mclk), .reset(reset), .req_valid(req_valid),
	.req_ready(req_ready), .resp_valid(resp_valid),
	.byte_address(byte_address),
	.id_space_select_line_hv(id_space_select_line_hv),
	.chip_select_n(chip_select_n), .output_drive_n(output_drive_n),
	.output_drive_hv(output_drive_hv), .write_strobe_n(write_strobe_n),
	.data_bus_out(data_bus_out), .data_bus_oe(data_bus_oe), .busy_n(busy_n));
`default_nettype wire

// [eeprom_device_model.sv]
// Purpose: behavioural 2K x 8 eeprom with 32 id bytes
// Assumes: pins change just after mclk edges
// Notes: write length set by wr_len, at least 1
`timescale 1ns/100ps
`default_nettype none
module eeprom_device_model (
	// clock and reset
	input wire logic mclk,
	input wire logic reset,
	// supply sense and write time
	input wire logic supply_ok,
	input wire logic [7:0] wr_len,
	// pins
	input wire logic [10:0] addr,
	input wire logic id_hv,
	input wire logic cs_n,
	input wire logic oe_n,
	input wire logic oe_hv,
	input wire logic we_n,
	input wire logic [7:0] din,
	output logic [7:0] dq,
	output logic dq_oe,
	output logic busy
);
	logic [7:0] mem [0:2079];
	logic [7:0] wdat, cnt;
	logic [11:0] wadr, idx;
	logic [5:0] pon, clr;
	logic pulse, pulse_q;
	// id bytes sit above the main array
	assign idx = id_hv ? 12'h0800 + addr[4:0] : {1'b0, addr};
	assign pulse = !cs_n && !we_n && oe_n && !oe_hv;
	assign dq_oe = !cs_n && !oe_n && we_n;
	// low bits of the byte under write churn while busy so nobody trusts them
	assign dq = (busy && idx == wadr) ? {~wdat[7], cnt[6:0]} : mem[idx];
	initial for (int i = 0; i < 2080; i++) mem[i] = 8'(i * 7) ^ 8'h5a;
	// write engine, clear and power-on lockout
	always @(posedge mclk or posedge reset) begin
		if (reset) begin
			busy <= 1'b0;
			pulse_q <= 1'b0;
			pon <= 6'h00;
			clr <= 6'h00;
		end else begin
			pulse_q <= pulse;
			if (pon != 6'h0f) pon <= pon + 6'h01;
			clr <= (!cs_n && oe_hv && !we_n) ? clr + (clr != 6'h3f) : 6'h00;
			if (we_n && clr >= 6'h1e) begin
				for (int i = 0; i < 2048; i++) mem[i] <= 8'hff;
			end
			if (busy) begin
				cnt <= cnt - 8'h01;
				if (cnt == 8'h01) begin
					busy <= 1'b0;
					mem[wadr] <= wdat;
				end
			end else if (pulse && !pulse_q) begin
				wadr <= idx;
			end else if (!pulse && pulse_q && supply_ok && pon == 6'h0f) begin
				wdat <= din;
				busy <= 1'b1;
				cnt <= wr_len;
			end
		end
	end
endmodule // eeprom_device_model
`default_nettype wire

// [eeprom_host_test.sv]
// Purpose: self-checking bench for the eeprom host controller
// Assumes: shortened power-on, timeout and clear counts
// Notes: random traffic from a fixed seed plus corners
`timescale 1ns/100ps
`default_nettype none
module eeprom_host_test;
	logic mclk = 0, reset = 1, req_valid = 0, req_id_space = 0, supply_ok = 1;
	logic [1:0] req_cmd = 0;
	logic [10:0] req_addr = 0, a;
	logic [7:0] req_wdata = 0, wr_len = 8'h14, bus_last = 0, d;
	logic [7:0] shadow [0:2079];
	wire logic req_ready, resp_valid, resp_timeout, id_hv, cs_n, oe_n, oe_hv;
	wire logic we_n, data_bus_oe, dev_oe, busy, busy_n;
	wire logic [10:0] byte_address;
	wire logic [7:0] resp_rdata, data_bus_out, dev_dq, data_bus_in;
	int error_cnt = 0, n_tests = 0, cyc = 0;
	// ---------------------------------------------
	// clock, wired bus and open-drain busy
	// ---------------------------------------------
	always #50 mclk = ~mclk;
	assign busy_n = ~busy;
	// a released bus shows the inverse of its last level
	assign data_bus_in = data_bus_oe ? data_bus_out : dev_oe ? dev_dq : ~bus_last;
	always @(posedge mclk) bus_last <= data_bus_in;
	eeprom_host #(.POWER_ON_CYCLES(20), .WRITE_TIMEOUT_CYCLES(200),
		.CLEAR_PULSE_CYCLES(30)) uut (.mclk(mclk), .reset(reset),
		.req_valid(req_valid), .req_cmd(req_cmd), .req_id_space(req_id_space),
		.req_addr(req_addr), .req_wdata(req_wdata), .req_ready(req_ready),
		.resp_valid(resp_valid), .resp_rdata(resp_rdata),
		.resp_timeout(resp_timeout), .byte_address(byte_address),
		.id_space_select_line_hv(id_hv), .chip_select_n(cs_n),
		.output_drive_n(oe_n), .output_drive_hv(oe_hv), .write_strobe_n(we_n),
		.data_bus_in(data_bus_in), .data_bus_out(data_bus_out),
		.data_bus_oe(data_bus_oe), .busy_n(busy_n));
	eeprom_device_model dev (.mclk(mclk), .reset(reset), .supply_ok(supply_ok),
		.wr_len(wr_len), .addr(byte_address), .id_hv(id_hv), .cs_n(cs_n),
		.oe_n(oe_n), .oe_hv(oe_hv), .we_n(we_n), .din(data_bus_in),
		.dq(dev_dq), .dq_oe(dev_oe), .busy(busy));
	// ---------------------------------------------
	// tasks
	// ---------------------------------------------
	task automatic check(input string what, input logic [7:0] seen, exp);
		n_tests++;
		if (seen !== exp) begin
			error_cnt++;
			$display("Error %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic close_out;
		$display("checks %0d errors %0d", n_tests, error_cnt);
		if (error_cnt == 0 && n_tests > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	// one request; waits are bounded by the cycle ceiling
	task automatic op(input logic [1:0] c, input logic id, input logic [10:0] ad,
		input logic [7:0] dt);
		@(posedge mclk) #1;
		while (req_ready !== 1'b1) @(posedge mclk) #1;
		@(posedge mclk) begin
			req_valid <= 1'b1;
			req_cmd <= c;
			req_id_space <= id;
			req_addr <= ad;
			req_wdata <= dt;
		end
		@(posedge mclk) req_valid <= 1'b0;
		#1;
		while (resp_valid !== 1'b1) @(posedge mclk) #1;
	endtask
	function automatic int ix(input logic id, input logic [10:0] ad);
		return id ? 2048 + ad[4:0] : ad;
	endfunction
	// write then read back, keeping the shadow copy
	task automatic wr_rd(input logic id, input logic [10:0] ad, input logic [7:0] dt);
		op(2'h1, id, ad, dt);
		check("write timeout", {7'h00, resp_timeout}, {7'h00, !supply_ok});
		if (supply_ok) shadow[ix(id, ad)] = dt;
		op(2'h0, id, ad, 8'h00);
		check("read data", resp_rdata, shadow[ix(id, ad)]);
	endtask
	// cycle ceiling
	always @(posedge mclk) begin
		cyc <= cyc + 1;
		if (cyc == 40000) begin
			error_cnt++;
			close_out;
		end
	end
	// ---------------------------------------------
	// main sequence
	// ---------------------------------------------
	initial begin
		for (int i = 0; i < 2080; i++) shadow[i] = 8'(i * 7) ^ 8'h5a;
		void'($urandom(32'h1f24));
		repeat (16) @(posedge mclk);
		reset <= 1'b0;
		repeat (8) @(posedge mclk);
		#1 check("ready in power-on", {7'h00, req_ready}, 8'h00);
		op(2'h0, 1'b0, 11'h7ff, 8'h00);
		check("read top", resp_rdata, shadow[2047]);
		for (int i = 0; i < 14; i++) begin
			a = (i == 0) ? 11'h000 : (i == 1) ? 11'h7ff : 11'($urandom);
			d = 8'($urandom);
			wr_len <= 8'h02 + 8'($urandom % 140);
			wr_rd(1'b0, a, d);
			if (i == 2) wr_rd(1'b0, a, ~d);
		end
		wr_rd(1'b1, 11'h7e0, 8'h3c);
		wr_rd(1'b1, 11'h7ff, 8'hc3);
		op(2'h0, 1'b0, 11'h7e0, 8'h00);
		check("main under id", resp_rdata, shadow[2016]);
		supply_ok <= 1'b0;
		wr_rd(1'b0, 11'h123, ~shadow[291]);
		supply_ok <= 1'b1;
		op(2'h2, 1'b0, 11'h000, 8'h00);
		for (int i = 0; i < 2048; i++) shadow[i] = 8'hff;
		for (int i = 0; i < 6; i++) begin
			a = 11'($urandom);
			op(2'h0, 1'b0, a, 8'h00);
			check("cleared byte", resp_rdata, 8'hff);
		end
		wr_rd(1'b0, 11'h055, 8'h00);
		close_out;
	end
endmodule // eeprom_host_test
`default_nettype wire
